// ---- logic/adc_port_pkg.sv ----
`default_nettype none
package adc_port_pkg;
   // result word and frame layout
   localparam int           RES_W        = 12;
   localparam int           PAD_W        = 4;
   localparam int           FRAME_W      = RES_W + PAD_W;
   localparam logic [4:0]   FRAME_LAST   = 5'h10;
   localparam logic [4:0]   FRAME_FIRST  = 5'h01;
   localparam logic [PAD_W-1:0] PAD_VAL  = 4'h0;
   localparam logic [RES_W-1:0] ZERO_CODE = 12'h000;
   localparam logic [FRAME_W-1:0] ZERO_WORD = 16'h0000;

   // conversion timing on the internal clock
   localparam int           CLK_PERIOD_NS = 50;
   localparam int           CONV_TIME_NS  = 3500;
   localparam int           CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int           STEP_CYC      = 5;
   localparam logic [6:0]   CONV_LAST     = 7'(CONV_CYC - 1);
   localparam logic [2:0]   STEP_LAST     = 3'(STEP_CYC - 1);
   localparam logic [3:0]   BIT_TOP       = 4'(RES_W - 1);
   localparam logic [3:0]   BIT_DONE      = 4'hf;

   // result buffer
   localparam int           FIFO_DEPTH    = 8;

   typedef enum logic [1:0] {
      LNK_IDLE    = 2'b00,
      LNK_WAIT_FS = 2'b01,
      LNK_SHIFT   = 2'b10
   } link_state_t;

   typedef enum logic [1:0] {
      SEQ_SLEEP   = 2'b00,
      SEQ_CONVERT = 2'b01,
      SEQ_DONE    = 2'b10
   } seq_state_t;

   // one-hot trial bit of the approximation register
   function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] idx);
      bit_mask = ZERO_CODE;
      if (idx <= BIT_TOP) begin
         bit_mask[idx] = 1'b1;
      end
   endfunction : bit_mask
endpackage : adc_port_pkg
`default_nettype wire

// ---- logic/serial_adc_result_port.sv ----
`timescale 1ns/100ps
`default_nettype none

// result buffer between the converter and the serial port
module result_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW:0]      wr_ff;
   logic [PW:0]      rd_ff;
   logic [PW:0]      nxt_wr;
   logic [PW:0]      nxt_rd;
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (wr_ff[PW] == rd_ff[PW]) || (wr_ff[PW-1:0] != rd_ff[PW-1:0]);
   assign out_valid = (wr_ff != rd_ff);
   assign out_data  = mem_ff[rd_ff[PW-1:0]];
   assign do_wr     = in_valid && in_ready;
   assign do_rd     = out_valid && out_ready;

   always_comb begin
      nxt_wr = do_wr ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = do_rd ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_ff[wr_ff[PW-1:0]] <= in_data;
      end
   end
endmodule : result_fifo

// Behaviour
// - the serial result output stays undriven until chip select falls or frame sync rises, whichever is first.
// - the result is shifted out most significant bit first.
// - each conversion yields one 12-bit result word that is sent over the serial output.
// - with frame sync high at the chip-select fall, the MSB is shown for the first falling shift-clock edge.
// - with frame sync low at the chip-select fall, the MSB is shown right after that fall.
// - with chip select held low, the MSB is shown after frame sync rises and read on the first falling edge after frame sync falls again.
// - conversion is timed by the internal clock, not the shift clock, and lasts 3.5 us.
// - the device drops into low power by itself whenever it neither converts nor transfers.
// - a frame is sixteen clocks, twelve result bits then four padding bits, then the output floats again.
// - the result is straight binary, zero at ground and all ones one step under the reference.
// - the output changes on rising shift-clock edges so the host samples on falling ones.
module serial_adc_result_port
   import adc_port_pkg::*;
(
   // internal conversion clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // serial link from the host
   input  wire logic             shift_clk,
   input  wire logic             cs_n,
   input  wire logic             frame_sync_in,
   output logic                  result_serial_out,
   output logic                  result_serial_oe,
   // analog front end
   input  wire logic             cmp_in,
   output logic [RES_W-1:0]      dac_code,
   output logic                  power_down
);
   // ---------------- internal clock domain ----------------
   seq_state_t       state_ff;
   seq_state_t       nxt_state;
   logic [RES_W-1:0] sar_ff;
   logic [RES_W-1:0] nxt_sar;
   logic [3:0]       bit_ff;
   logic [3:0]       nxt_bit;
   logic [2:0]       step_ff;
   logic [2:0]       nxt_step;
   logic [6:0]       cnt_ff;
   logic [6:0]       nxt_cnt;
   logic             pd_ff;
   logic             nxt_pd;
   logic [RES_W-1:0] tx_word_ff;
   logic [RES_W-1:0] nxt_tx_word;
   logic             req_tgl_ff;
   logic             nxt_req_tgl;
   logic             cmp_s1_ff;
   logic             cmp_s2_ff;
   logic             start_s1_ff;
   logic             start_s2_ff;
   logic             start_s3_ff;
   logic             busy_s1_ff;
   logic             busy_s2_ff;
   logic             ack_s1_ff;
   logic             ack_s2_ff;
   logic             start_evt;
   logic             pending;
   logic             fifo_in_valid;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic             fifo_out_ready;
   logic [RES_W-1:0] fifo_out_data;

   // ---------------- link clock domain ----------------
   link_state_t        lnk_ff;
   link_state_t        nxt_lnk;
   logic [FRAME_W-1:0] sh_ff;
   logic [FRAME_W-1:0] nxt_sh;
   logic [4:0]         bcnt_ff;
   logic [4:0]         nxt_bcnt;
   logic               sdo_ff;
   logic               nxt_sdo;
   logic               oe_ff;
   logic               nxt_oe;
   logic               cs_prev_ff;
   logic               fs_prev_ff;
   logic               start_tgl_ff;
   logic               nxt_start_tgl;
   logic               busy_ff;
   logic               nxt_busy;
   logic               ack_tgl_ff;
   logic               nxt_ack_tgl;
   logic               req_s1_ff;
   logic               req_s2_ff;
   logic               new_word;
   logic               cs_fall;
   logic               fs_rise;

   // crossings into the internal domain
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_s1_ff   <= 1'b0;
         cmp_s2_ff   <= 1'b0;
         start_s1_ff <= 1'b0;
         start_s2_ff <= 1'b0;
         start_s3_ff <= 1'b0;
         busy_s1_ff  <= 1'b0;
         busy_s2_ff  <= 1'b0;
         ack_s1_ff   <= 1'b0;
         ack_s2_ff   <= 1'b0;
      end else begin
         cmp_s1_ff   <= cmp_in;
         cmp_s2_ff   <= cmp_s1_ff;
         start_s1_ff <= start_tgl_ff;
         start_s2_ff <= start_s1_ff;
         start_s3_ff <= start_s2_ff;
         busy_s1_ff  <= busy_ff;
         busy_s2_ff  <= busy_s1_ff;
         ack_s1_ff   <= ack_tgl_ff;
         ack_s2_ff   <= ack_s1_ff;
      end
   end

   assign start_evt     = start_s2_ff ^ start_s3_ff;
   assign pending       = req_tgl_ff ^ ack_s2_ff;
   assign fifo_in_valid = (state_ff == SEQ_DONE);
   assign fifo_out_ready = !pending;

   // successive approximation sequencer on the internal clock
   always_comb begin
      nxt_state = state_ff;
      nxt_sar   = sar_ff;
      nxt_bit   = bit_ff;
      nxt_step  = step_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         SEQ_SLEEP: begin
            if (start_evt) begin
               nxt_state = SEQ_CONVERT;
               nxt_sar   = bit_mask(BIT_TOP);
               nxt_bit   = BIT_TOP;
               nxt_step  = 3'h0;
               nxt_cnt   = 7'h00;
            end
         end
         SEQ_CONVERT: begin
            nxt_cnt  = cnt_ff + 7'h01;
            nxt_step = step_ff + 3'h1;
            if (step_ff == STEP_LAST && bit_ff != BIT_DONE) begin
               nxt_step = 3'h0;
               // keep the trial bit while the input is at or above it
               if (!cmp_s2_ff) begin
                  nxt_sar = nxt_sar & ~bit_mask(bit_ff);
               end
               if (bit_ff == 4'h0) begin
                  nxt_bit = BIT_DONE;
               end else begin
                  nxt_bit = bit_ff - 4'h1;
                  nxt_sar = nxt_sar | bit_mask(nxt_bit);
               end
            end
            if (cnt_ff == CONV_LAST) begin
               nxt_state = SEQ_DONE;
            end
         end
         SEQ_DONE: begin
            if (fifo_in_ready) begin
               nxt_state = SEQ_SLEEP;
            end
         end
         default: begin
            nxt_state = SEQ_SLEEP;
         end
      endcase
      nxt_pd = (nxt_state == SEQ_SLEEP) && !busy_s2_ff;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SEQ_SLEEP;
         sar_ff   <= ZERO_CODE;
         bit_ff   <= BIT_DONE;
         step_ff  <= 3'h0;
         cnt_ff   <= 7'h00;
         pd_ff    <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         sar_ff   <= nxt_sar;
         bit_ff   <= nxt_bit;
         step_ff  <= nxt_step;
         cnt_ff   <= nxt_cnt;
         pd_ff    <= nxt_pd;
      end
   end

   result_fifo #(
      .WIDTH (RES_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (sar_ff),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // hand the next result to the link, held until it is taken
   always_comb begin
      nxt_tx_word = tx_word_ff;
      nxt_req_tgl = req_tgl_ff;
      if (fifo_out_valid && !pending) begin
         nxt_tx_word = fifo_out_data;
         nxt_req_tgl = !req_tgl_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_ff <= ZERO_CODE;
         req_tgl_ff <= 1'b0;
      end else begin
         tx_word_ff <= nxt_tx_word;
         req_tgl_ff <= nxt_req_tgl;
      end
   end

   // crossing into the link domain
   always_ff @(posedge shift_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
      end else begin
         req_s1_ff <= req_tgl_ff;
         req_s2_ff <= req_s1_ff;
      end
   end

   assign new_word = req_s2_ff ^ ack_tgl_ff;
   assign cs_fall  = cs_prev_ff && !cs_n;
   assign fs_rise  = !fs_prev_ff && frame_sync_in;

   // serial frame engine, all changes on rising shift-clock edges
   always_comb begin
      nxt_lnk       = lnk_ff;
      nxt_sh        = sh_ff;
      nxt_bcnt      = bcnt_ff;
      nxt_sdo       = sdo_ff;
      nxt_oe        = oe_ff;
      nxt_start_tgl = start_tgl_ff;
      nxt_busy      = busy_ff;
      nxt_ack_tgl   = ack_tgl_ff;
      if (cs_n) begin
         nxt_lnk  = LNK_IDLE;
         nxt_oe   = 1'b0;
         nxt_busy = 1'b0;
         if (new_word) begin
            nxt_sh      = {tx_word_ff, PAD_VAL};
            nxt_ack_tgl = !ack_tgl_ff;
         end
      end else begin
         case (lnk_ff)
            LNK_IDLE: begin
               if (cs_fall || fs_rise) begin
                  nxt_oe   = 1'b1;
                  nxt_sdo  = sh_ff[FRAME_W-1];
                  nxt_sh   = sh_ff << 1;
                  nxt_bcnt = FRAME_FIRST;
                  nxt_busy = 1'b1;
                  if (cs_fall && frame_sync_in) begin
                     nxt_lnk       = LNK_SHIFT;
                     nxt_start_tgl = !start_tgl_ff;
                  end else begin
                     nxt_lnk = LNK_WAIT_FS;
                  end
               end else if (new_word) begin
                  nxt_sh      = {tx_word_ff, PAD_VAL};
                  nxt_ack_tgl = !ack_tgl_ff;
               end
            end
            LNK_WAIT_FS: begin
               if (!frame_sync_in) begin
                  nxt_lnk       = LNK_SHIFT;
                  nxt_start_tgl = !start_tgl_ff;
               end
            end
            LNK_SHIFT: begin
               // frame word shifts left each clock and takes no new result until the frame ends
               if (bcnt_ff == FRAME_LAST) begin
                  nxt_oe   = 1'b0;
                  nxt_lnk  = LNK_IDLE;
                  nxt_busy = 1'b0;
               end else begin
                  nxt_sdo  = sh_ff[FRAME_W-1];
                  nxt_sh   = sh_ff << 1;
                  nxt_bcnt = bcnt_ff + 5'h01;
               end
            end
            default: begin
               nxt_lnk = LNK_IDLE;
               nxt_oe  = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge shift_clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk_ff       <= LNK_IDLE;
         sh_ff        <= ZERO_WORD;
         bcnt_ff      <= 5'h00;
         sdo_ff       <= 1'b0;
         oe_ff        <= 1'b0;
         cs_prev_ff   <= 1'b1;
         fs_prev_ff   <= 1'b1;
         start_tgl_ff <= 1'b0;
         busy_ff      <= 1'b0;
         ack_tgl_ff   <= 1'b0;
      end else begin
         lnk_ff       <= nxt_lnk;
         sh_ff        <= nxt_sh;
         bcnt_ff      <= nxt_bcnt;
         sdo_ff       <= nxt_sdo;
         oe_ff        <= nxt_oe;
         cs_prev_ff   <= cs_n;
         fs_prev_ff   <= frame_sync_in;
         start_tgl_ff <= nxt_start_tgl;
         busy_ff      <= nxt_busy;
         ack_tgl_ff   <= nxt_ack_tgl;
      end
   end

   assign result_serial_out = sdo_ff;
   assign result_serial_oe  = oe_ff;
   assign dac_code          = sar_ff;
   assign power_down        = pd_ff;
endmodule : serial_adc_result_port
`default_nettype wire

// ---- verif/adc_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
   // link toward the converter
   output logic      shift_clk,
   output logic      cs_n,
   output logic      frame_sync_in,
   input  wire logic result_serial_out,
   input  wire logic result_serial_oe
);
   int   errs = 0;
   logic last_bit = 1'b0;
   // a floating line shows the inverse of its last value
   wire  line_lvl = result_serial_oe ? result_serial_out : ~last_bit;

   initial begin
      shift_clk     = 1'b0;
      cs_n          = 1'b1;
      frame_sync_in = 1'b1;
   end

   // one link clock period
   task automatic pulse();
      #6 shift_clk = 1'b1;
      #6 shift_clk = 1'b0;
   endtask : pulse

   // idle clocks between frames, fs follows cs
   task automatic idle(input logic cs_lvl, input int n);
      cs_n          = cs_lvl;
      frame_sync_in = cs_lvl;
      repeat (n) begin
         pulse();
         if (result_serial_oe !== 1'b0) errs++;
      end
   endtask : idle

   // mode 0: cs falls, fs high; 1: fs rises, cs low; 2: cs falls, fs low
   task automatic frame(input int mode, input int nbits, output logic [15:0] word);
      word = 16'h0000;
      cs_n = 1'b0; // chip select doubles as frame mark
      if (mode != 0) begin
         frame_sync_in = (mode == 1);
         pulse();
         if (mode == 2) begin
            frame_sync_in = 1'b1;
            pulse();
         end
         if (result_serial_oe !== 1'b1) errs++;
         frame_sync_in = 1'b0;
      end
      for (int i = 0; i < nbits; i++) begin
         #6 shift_clk = 1'b1;
         #6 if (result_serial_oe !== 1'b1) errs++;
         word      = {word[14:0], line_lvl};
         last_bit  = line_lvl;
         shift_clk = 1'b0;
      end
      if (nbits < 16) cs_n = 1'b1;
      pulse();
      if (result_serial_oe !== 1'b0) errs++;
   endtask : frame
endmodule : adc_host_model
`default_nettype wire

// ---- verif/port_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module port_checker
   import adc_port_pkg::*;
(
   // clocks and reset
   input wire logic             ref_clk,
   input wire logic             rst_n,
   input wire logic             shift_clk,
   // serial link
   input wire logic             cs_n,
   input wire logic             frame_sync_in,
   input wire logic             result_serial_out,
   input wire logic             result_serial_oe,
   // analog front end
   input wire logic             cmp_in,
   input wire logic [RES_W-1:0] dac_code,
   input wire logic             power_down
);
   logic [2:0]       gap_ff;
   logic [2:0]       nxt_gap;
   logic [7:0]       awake_ff;
   logic [7:0]       nxt_awake;
   logic [RES_W-1:0] dac_prev_ff;

   // cycles since the trial code last moved, and cycles spent awake
   always_comb begin
      nxt_gap   = (dac_code != dac_prev_ff) ? 3'h0 : ((gap_ff == 3'h7) ? gap_ff : gap_ff + 3'h1);
      nxt_awake = power_down ? 8'h00 : ((awake_ff == 8'hff) ? awake_ff : awake_ff + 8'h01);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_ff      <= 3'h7;
         awake_ff    <= 8'h00;
         dac_prev_ff <= ZERO_CODE;
      end else begin
         gap_ff      <= nxt_gap;
         awake_ff    <= nxt_awake;
         dac_prev_ff <= dac_code;
      end
   end

   sequence cs_start;
      $fell(cs_n) && frame_sync_in;
   endsequence

   sequence low_eight;
      (!cs_n)[*8];
   endsequence

   a_idle_float: assert property (@(posedge shift_clk) disable iff (!rst_n)
      cs_n |=> !result_serial_oe) else $error("output driven while deselected");
   a_cs_drive: assert property (@(posedge shift_clk) disable iff (!rst_n)
      $fell(cs_n) |=> result_serial_oe) else $error("no output after chip select fall");
   a_fs_drive: assert property (@(posedge shift_clk) disable iff (!rst_n)
      !cs_n && !$past(cs_n) && $rose(frame_sync_in) && !result_serial_oe |=> result_serial_oe)
      else $error("no output after frame sync rise");
   a_frame_hold: assert property (@(posedge shift_clk) disable iff (!rst_n)
      cs_start |=> (result_serial_oe || cs_n)[*8]) else $error("output dropped early in frame");
   a_frame_end: assert property (@(posedge shift_clk) disable iff (!rst_n)
      cs_start ##1 low_eight ##1 low_eight |=> !result_serial_oe) else $error("output not released");
   a_pad_zero: assert property (@(posedge shift_clk) disable iff (!rst_n)
      cs_start ##1 low_eight ##1 (!cs_n)[*4] |=> (!result_serial_out || cs_n)[*4])
      else $error("padding bit not zero");
   a_wake_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$stable(dac_code) |-> !power_down || !$past(power_down)) else $error("trial moved while asleep");
   a_step_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$stable(dac_code) |-> gap_ff >= 3'h4) else $error("trial step too short");
   a_sleep_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
      awake_ff < 8'hc8) else $error("awake too long");
endmodule : port_checker
`default_nettype wire

// ---- verif/serial_adc_result_port_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
$display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module serial_adc_result_port_bench
   import adc_port_pkg::*;
;
   logic             ref_clk;
   logic             rst_n;
   logic             cmp_in;
   logic             shift_clk;
   logic             cs_n;
   logic             frame_sync_in;
   logic             result_serial_out;
   logic             result_serial_oe;
   logic             power_down;
   logic [RES_W-1:0] dac_code;
   logic [RES_W-1:0] vin;
   logic [RES_W-1:0] prev;
   logic [15:0]      word;
   int               failures;
   int               tests_run;
   int               cycles;

   serial_adc_result_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .shift_clk(shift_clk), .cs_n(cs_n),
      .frame_sync_in(frame_sync_in), .result_serial_out(result_serial_out),
      .result_serial_oe(result_serial_oe), .cmp_in(cmp_in), .dac_code(dac_code), .power_down(power_down));

   adc_host_model host (.shift_clk(shift_clk), .cs_n(cs_n), .frame_sync_in(frame_sync_in),
      .result_serial_out(result_serial_out), .result_serial_oe(result_serial_oe));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // comparator against the held input level
   always @(posedge ref_clk) cmp_in <= (vin >= dac_code);

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // conversion runs with the shift clock stopped, then sleep
   task automatic settle();
      repeat (30) @(posedge ref_clk);
      #1 `CHECK(power_down, 1'b0)
      repeat (80) @(posedge ref_clk);
      #1 `CHECK(power_down, 1'b1)
      `CHECK(host.errs, 0)
   endtask : settle

   task automatic run_frame(input int mode, input logic [RES_W-1:0] v);
      @(posedge ref_clk) vin <= v;
      host.idle(mode != 1, 4);
      host.frame(mode, 16, word);
      `CHECK(word, {prev, 4'h0})
      prev = v;
      settle();
   endtask : run_frame

   task automatic t_cs_mode();
      run_frame(0, 12'hfff);
      run_frame(0, 12'h000);
      run_frame(0, 12'h5a3);
   endtask : t_cs_mode

   task automatic t_abort();
      @(posedge ref_clk) vin <= 12'h3c6;
      host.idle(1'b1, 4);
      host.frame(0, 4, word);
      `CHECK(word[3:0], prev[11:8])
      prev = 12'h3c6;
      settle();
   endtask : t_abort

   task automatic t_dsp_modes();
      run_frame(2, 12'hc39);
      run_frame(1, 12'h0f0);
      run_frame(0, 12'h000);
   endtask : t_dsp_modes

   initial begin
      rst_n  = 1'b0;
      vin    = 12'h000;
      prev   = 12'h000;
      host.idle(1'b1, 4);
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_cs_mode();
      t_abort();
      t_dsp_modes();
      print_verdict();
   end
endmodule : serial_adc_result_port_bench

bind serial_adc_result_port port_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .shift_clk(shift_clk),
   .cs_n(cs_n), .frame_sync_in(frame_sync_in), .result_serial_out(result_serial_out),
   .result_serial_oe(result_serial_oe), .cmp_in(cmp_in), .dac_code(dac_code), .power_down(power_down));
`default_nettype wire
